/* hdl/dsap_fifo.v */
// parameterised flip-flop FIFO with valid/ready on both sides
`timescale 1ns/100ps
module dsap_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 8,
	parameter AW    = 3
) (
	input  wire             clk_i,
	input  wire             rst_b_i,
	input  wire [WIDTH-1:0] in_data_i,
	input  wire             in_valid_i,
	output wire             in_ready_o,
	output reg  [WIDTH-1:0] out_data_o,
	output wire             out_valid_o,
	input  wire             out_ready_i
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0]    wr_ptr;
	reg [AW-1:0]    rd_ptr;
	reg [AW:0]      count;
	wire            push;
	wire            pop;
	integer         i;

	assign in_ready_o  = (count != DEPTH);
	assign out_valid_o = (count != 0);
	assign push        = in_valid_i & in_ready_o;
	assign pop         = out_valid_o & out_ready_i;

	always @* begin
		out_data_o = mem[rd_ptr];
	end

	always @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			wr_ptr <= {AW{1'b0}};
			rd_ptr <= {AW{1'b0}};
			count  <= {(AW+1){1'b0}};
			for (i = 0; i < DEPTH; i = i + 1)
				mem[i] <= {WIDTH{1'b0}};
		end else begin
			if (push) begin
				mem[wr_ptr] <= in_data_i;
				wr_ptr      <= wr_ptr + 1'b1;
			end
			if (pop)
				rd_ptr <= rd_ptr + 1'b1;
			if (push & ~pop)
				count <= count + 1'b1;
			else if (pop & ~push)
				count <= count - 1'b1;
		end
	end
endmodule // dsap_fifo

/* hdl/dsap_port.v */
// single-wire debug serial port with autobaud
`timescale 1ns/100ps
`include "dsap_map.vh"
module dsap_port (
	input  wire       CLK_I,
	input  wire       RST_B_I,
	input  wire       POR_I,
	input  wire       BROWNOUT_I,
	input  wire       WDT_RST_I,
	input  wire       PIN_RST_I,
	input  wire       MODE_CLEAR_I,
	input  wire       STOP_MODE_I,
	input  wire       DEBUG_LINE_I,
	output reg        DEBUG_LINE_O,
	output reg        DEBUG_LINE_OE_B_O,
	output reg        SYS_RESET_O,
	output reg        DEBUG_MODE_FLAG_O,
	output reg        BAUD_VALID_O,
	output wire [7:0] RX_DATA_O,
	output wire       RX_VALID_O,
	input  wire       RX_READY_I,
	input  wire [7:0] TX_DATA_I,
	input  wire       TX_VALID_I,
	output wire       TX_READY_O
);
	//------------------------------------------------------------
	// input synchroniser
	//------------------------------------------------------------
	reg        line_s1;
	reg        line_s2;
	reg        line_d;
	always @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			line_s1 <= 1'b1;
			line_s2 <= 1'b1;
			line_d  <= 1'b1;
		end else begin
			line_s1 <= DEBUG_LINE_I;
			line_s2 <= line_s1;
			line_d  <= line_s2;
		end
	end
	wire fall = line_d & ~line_s2;

	// any system reset ends debug mode and forgets the rate
	wire any_rst = POR_I | BROWNOUT_I | WDT_RST_I | PIN_RST_I;

	//------------------------------------------------------------
	// stop-mode wake reset
	//------------------------------------------------------------
	always @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I)
			SYS_RESET_O <= 1'b0;
		else
			SYS_RESET_O <= STOP_MODE_I & ~line_s2;
	end

	//------------------------------------------------------------
	// receiver with autobaud
	//------------------------------------------------------------
	localparam RX_CAL  = 3'h0;
	localparam RX_CALL = 3'h1;
	localparam RX_IDLE = 3'h2;
	localparam RX_BITS = 3'h3;
	localparam RX_WAIT = 3'h4;

	reg [2:0]             rx_state;
	reg [`DSAP_CNT_W-1:0] cal_cnt;
	reg [`DSAP_BIT_W-1:0] bit_len;
	reg [`DSAP_BIT_W-1:0] rx_cnt;
	reg [3:0]             rx_idx;
	reg [7:0]             rx_shift;
	reg [7:0]             rx_byte;
	reg                   rx_push;
	wire                  rx_ready;

	// bit length: low run over eight bits, capped at clock/512
	function [`DSAP_BIT_W-1:0] cal_to_bit;
		input [`DSAP_CNT_W-1:0] run;
		reg   [`DSAP_CNT_W-1:0] q;
		begin
			q = run >> `DSAP_CAL_SHIFT;
			if (q > {3'h0, `DSAP_MAX_BIT})
				cal_to_bit = `DSAP_MAX_BIT;
			else if (q == {`DSAP_CNT_W{1'b0}})
				cal_to_bit = 10'h001;
			else
				cal_to_bit = q[`DSAP_BIT_W-1:0];
		end
	endfunction

	always @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			rx_state          <= RX_CAL;
			cal_cnt           <= {`DSAP_CNT_W{1'b0}};
			bit_len           <= `DSAP_MAX_BIT;
			rx_cnt            <= {`DSAP_BIT_W{1'b0}};
			rx_idx            <= 4'h0;
			rx_shift          <= 8'h00;
			rx_byte           <= 8'h00;
			rx_push           <= 1'b0;
			BAUD_VALID_O      <= 1'b0;
			DEBUG_MODE_FLAG_O <= 1'b0;
		end else if (any_rst) begin
			rx_state          <= RX_CAL;
			BAUD_VALID_O      <= 1'b0;
			DEBUG_MODE_FLAG_O <= 1'b0;
			rx_push           <= 1'b0;
		end else begin
			rx_push <= 1'b0;
			if (MODE_CLEAR_I)
				DEBUG_MODE_FLAG_O <= 1'b0;
			case (rx_state)
			RX_CAL: begin
				// the edge that sees the fall is the first low clock;
				// dropping it makes the bit one clock short
				cal_cnt <= {{(`DSAP_CNT_W-1){1'b0}}, fall};
				if (fall)
					rx_state <= RX_CALL;
			end
			RX_CALL: begin
				if (line_s2) begin
					bit_len           <= cal_to_bit(cal_cnt);
					BAUD_VALID_O      <= 1'b1;
					DEBUG_MODE_FLAG_O <= 1'b1;
					rx_cnt            <= {`DSAP_BIT_W{1'b0}};
					rx_state          <= RX_WAIT;
				end else if (cal_cnt != {`DSAP_CNT_W{1'b1}})
					cal_cnt <= cal_cnt + 1'b1;
			end
			RX_IDLE: begin
				if (fall) begin
					rx_cnt   <= bit_len >> 1;
					rx_idx   <= 4'h0;
					rx_state <= RX_BITS;
				end
			end
			RX_BITS: begin
				if (rx_cnt == {`DSAP_BIT_W{1'b0}}) begin
					rx_cnt <= bit_len - 1'b1;
					rx_idx <= rx_idx + 1'b1;
					if (rx_idx == 4'h0 && line_s2)
						rx_state <= RX_IDLE;
					else if (rx_idx == `DSAP_STOP_IDX) begin
						rx_state <= RX_IDLE;
						if (line_s2 & rx_ready) begin
							rx_byte <= rx_shift;
							rx_push <= 1'b1;
						end
					end else if (rx_idx != 4'h0)
						rx_shift <= {line_s2, rx_shift[7:1]};
				end else
					rx_cnt <= rx_cnt - 1'b1;
			end
			RX_WAIT: begin
				// let the high msb of the calibration byte pass
				if (rx_cnt == bit_len)
					rx_state <= RX_IDLE;
				else if (fall)
					rx_state <= RX_IDLE;
				else
					rx_cnt <= rx_cnt + 1'b1;
			end
			default: rx_state <= RX_CAL;
			endcase
		end
	end

	dsap_fifo #(
		.WIDTH(`DSAP_DATA_W),
		.DEPTH(`DSAP_FIFO_DEPTH),
		.AW   (`DSAP_FIFO_AW)
	) u_rx_fifo (
		.clk_i      (CLK_I),
		.rst_b_i    (RST_B_I),
		.in_data_i  (rx_byte),
		.in_valid_i (rx_push),
		.in_ready_o (rx_ready),
		.out_data_o (RX_DATA_O),
		.out_valid_o(RX_VALID_O),
		.out_ready_i(RX_READY_I)
	);

	//------------------------------------------------------------
	// transmitter
	//------------------------------------------------------------
	// a full fifo drops the byte; the host protocol waits for replies
	reg                   tx_busy;
	reg [9:0]             tx_frame;
	reg [3:0]             tx_idx;
	reg [`DSAP_BIT_W-1:0] tx_cnt;
	wire                  tx_ok = BAUD_VALID_O & ~any_rst;

	assign TX_READY_O = tx_ok & ~tx_busy;

	always @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			tx_busy           <= 1'b0;
			tx_frame          <= 10'h3FF;
			tx_idx            <= 4'h0;
			tx_cnt            <= {`DSAP_BIT_W{1'b0}};
			DEBUG_LINE_O      <= 1'b1;
			DEBUG_LINE_OE_B_O <= 1'b1;
		end else if (!tx_ok) begin
			tx_busy           <= 1'b0;
			DEBUG_LINE_O      <= 1'b1;
			DEBUG_LINE_OE_B_O <= 1'b1;
		end else if (!tx_busy) begin
			DEBUG_LINE_O      <= 1'b1;
			DEBUG_LINE_OE_B_O <= 1'b1;
			if (TX_VALID_I) begin
				tx_frame <= {1'b1, TX_DATA_I, 1'b0};
				tx_busy  <= 1'b1;
				tx_idx   <= 4'h0;
				tx_cnt   <= bit_len - 1'b1;
				DEBUG_LINE_O      <= 1'b0;
				DEBUG_LINE_OE_B_O <= 1'b0;
			end
		end else if (tx_cnt == {`DSAP_BIT_W{1'b0}}) begin
			if (tx_idx == `DSAP_LAST_BIT) begin
				tx_busy           <= 1'b0;
				DEBUG_LINE_O      <= 1'b1;
				DEBUG_LINE_OE_B_O <= 1'b1;
			end else begin
				tx_idx       <= tx_idx + 1'b1;
				tx_cnt       <= bit_len - 1'b1;
				DEBUG_LINE_O <= tx_frame[tx_idx + 1'b1];
				DEBUG_LINE_OE_B_O <= 1'b0;
			end
		end else
			tx_cnt <= tx_cnt - 1'b1;
	end
endmodule // dsap_port

/* include/dsap_map.vh */
// constants for the debug serial autobaud port
// Operation
// - leave debug mode on flag clear or resets
// - low debug line in stop resets system
// - frame is start, eight data lsb first, stop
// - reply may start right after stop bit
// - idle and silent until host data arrives
// - time calibration low run, load bit rate
// - system clock, rates down to clock/512
// - shared pin calibrates then enters debug mode
`ifndef DSAP_MAP_VH
`define DSAP_MAP_VH
`define DSAP_DATA_W     8
`define DSAP_FIFO_DEPTH 8
`define DSAP_FIFO_AW    3
`define DSAP_CNT_W      13
`define DSAP_BIT_W      10
`define DSAP_CAL_BITS   8
`define DSAP_CAL_SHIFT  3
`define DSAP_MAX_BIT    10'h200
`define DSAP_CAL_BYTE   8'h80
`define DSAP_LAST_BIT   4'h9
`define DSAP_STOP_IDX   4'h9
`endif

/* verif/dsap_host.sv */
// debug host model: open-drain driver of the debug line
`timescale 1ns/100ps
module dsap_host (
	input  logic clk_i,
	output logic pull_low_o
);
	initial pull_low_o = 1'b0;
	// only pulls low, never drives high, so a reply is never blocked
	task automatic send(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			pull_low_o = ~f[i];
			repeat (16) @(negedge clk_i);
		end
	endtask
	task automatic low(input int n);
		pull_low_o = 1'b1;
		repeat (n) @(negedge clk_i);
		pull_low_o = 1'b0;
	endtask
endmodule // dsap_host

/* verif/dsap_port_properties.sv */
// pin-level checks of the debug serial port
`timescale 1ns/100ps
module dsap_port_properties (
	input logic       CLK_I,
	input logic       RST_B_I,
	input logic       POR_I,
	input logic       BROWNOUT_I,
	input logic       WDT_RST_I,
	input logic       PIN_RST_I,
	input logic       MODE_CLEAR_I,
	input logic       STOP_MODE_I,
	input logic       DEBUG_LINE_I,
	input logic       DEBUG_LINE_O,
	input logic       DEBUG_LINE_OE_B_O,
	input logic       SYS_RESET_O,
	input logic       DEBUG_MODE_FLAG_O,
	input logic       BAUD_VALID_O,
	input logic       RX_VALID_O,
	input logic       RX_READY_I,
	input logic       TX_VALID_I,
	input logic       TX_READY_O,
	input logic [7:0] RX_DATA_O,
	input logic [7:0] TX_DATA_I
);
	default clocking @(posedge CLK_I); endclocking
	default disable iff (!RST_B_I);
	wire any_rst = POR_I | BROWNOUT_I | WDT_RST_I | PIN_RST_I;
	sequence tx_take;
		TX_VALID_I && TX_READY_O;
	endsequence
	sequence start_bit;
		!DEBUG_LINE_OE_B_O && !DEBUG_LINE_O;
	endsequence
	idle_quiet_a: assert property (
		!BAUD_VALID_O |-> DEBUG_LINE_OE_B_O && !TX_READY_O)
		else $error("line driven before rate known");
	release_high_a: assert property (
		DEBUG_LINE_OE_B_O |-> DEBUG_LINE_O) else $error("released low");
	start_frame_a: assert property (
		tx_take |=> start_bit [*8]) else $error("start bit missing");
	stop_reset_a: assert property (
		(STOP_MODE_I && !DEBUG_LINE_I) [*4] |-> SYS_RESET_O)
		else $error("no reset in stop");
	run_no_reset_a: assert property (
		!STOP_MODE_I && !$past(STOP_MODE_I) |-> !SYS_RESET_O)
		else $error("reset outside stop");
	flag_clear_a: assert property (
		MODE_CLEAR_I |=> !DEBUG_MODE_FLAG_O || $rose(BAUD_VALID_O))
		else $error("flag kept");
	reset_exit_a: assert property (
		any_rst |=> !DEBUG_MODE_FLAG_O && !BAUD_VALID_O)
		else $error("mode kept over reset");
	mode_baud_a: assert property (
		$rose(DEBUG_MODE_FLAG_O) |-> BAUD_VALID_O) else $error("no rate");
	rx_hold_a: assert property (
		RX_VALID_O && !RX_READY_I |=> RX_VALID_O && $stable(RX_DATA_O))
		else $error("rx data not held");
endmodule // dsap_port_properties
bind dsap_port dsap_port_properties chk (.*);

/* verif/tb.sv */
// self-checking bench for the debug serial port
`timescale 1ns/100ps
module tb;
	logic clk = 0, rst_b = 0, clr = 0, stp = 0, rx_rdy = 0, txv = 0;
	logic [3:0] rv = 0;
	logic [7:0] txd = 0, rxd, b;
	logic o, oe_b, sysr, flag, baud, rxv, txr, pull;
	int error_cnt = 0, n_checks = 0, n;
	wire line = !(pull || (!oe_b && !o));
	initial forever #50 clk = ~clk;
	dsap_host host (.clk_i(clk), .pull_low_o(pull));
	dsap_port uut (.CLK_I(clk), .RST_B_I(rst_b), .POR_I(rv[0]),
		.BROWNOUT_I(rv[1]), .WDT_RST_I(rv[2]), .PIN_RST_I(rv[3]),
		.MODE_CLEAR_I(clr), .STOP_MODE_I(stp), .DEBUG_LINE_I(line),
		.DEBUG_LINE_O(o), .DEBUG_LINE_OE_B_O(oe_b), .SYS_RESET_O(sysr),
		.DEBUG_MODE_FLAG_O(flag), .BAUD_VALID_O(baud), .RX_DATA_O(rxd),
		.RX_VALID_O(rxv), .RX_READY_I(rx_rdy), .TX_DATA_I(txd),
		.TX_VALID_I(txv), .TX_READY_O(txr));
	task automatic chk(string nm, logic [7:0] s, logic [7:0] e);
		n_checks++;
		if (s !== e) begin
			error_cnt++;
			$display("[FAIL] %s exp %h seen %h", nm, e, s);
		end
	endtask
	task automatic summarize;
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// samples a device frame at mid-bit
	task automatic grab(output logic [7:0] v);
		for (n = 0; n < 2000 && line !== 1'b0; n++) @(negedge clk);
		repeat (8) @(negedge clk);
		for (int i = 0; i < 8; i++) begin
			repeat (16) @(negedge clk);
			v[i] = line;
		end
		repeat (16) @(negedge clk);
		chk("stop", line, 1);
	endtask
	task automatic t_idle;
		txv = 1;
		repeat (20) @(negedge clk);
		chk("oe_b", oe_b, 1);
		chk("txr", txr, 0);
		txv = 0;
		$display("idle done");
	endtask
	task automatic t_cal;
		host.send(8'h80);
		for (n = 0; n < 20 && baud !== 1'b1; n++) @(negedge clk);
		chk("baud", baud, 1);
		chk("mode", flag, 1);
		$display("cal done");
	endtask
	// far side stalls while the buffer fills past its depth
	task automatic t_fifo;
		for (int i = 0; i < 9; i++) host.send(8'(8'hA0 + i));
		for (int i = 0; i < 8; i++) begin
			chk("rxv", rxv, 1);
			chk("rxd", rxd, 8'(8'hA0 + i));
			rx_rdy = 1;
			@(negedge clk);
			rx_rdy = 0;
			@(negedge clk);
		end
		chk("empty", rxv, 0);
		$display("fifo done");
	endtask
	task automatic t_tx;
		host.send(8'h11);
		txd = 8'h3C;
		txv = 1;
		for (n = 0; n < 20 && txr !== 1'b1; n++) @(negedge clk);
		@(negedge clk);
		txv = 0;
		grab(b);
		chk("txd", b, 8'h3C);
		$display("tx done");
	endtask
	task automatic t_stop;
		stp = 1;
		host.low(6);
		chk("sysr", sysr, 1);
		stp = 0;
		repeat (4) @(negedge clk);
		chk("sysr", sysr, 0);
		$display("stop done");
	endtask
	task automatic t_exit;
		for (int i = 0; i < 4; i++) begin
			rv[i] = 1;
			@(negedge clk);
			rv[i] = 0;
			@(negedge clk);
			chk("rst", {baud, flag}, 0);
			t_cal;
		end
		clr = 1;
		@(negedge clk);
		clr = 0;
		@(negedge clk);
		chk("clr", flag, 0);
		$display("exit done");
	endtask
	initial begin
		repeat (8) @(negedge clk);
		rst_b = 1;
		t_idle;
		t_cal;
		t_fifo;
		t_tx;
		t_stop;
		t_exit;
		summarize;
	end
	initial begin
		repeat (20000) @(negedge clk);
		error_cnt++;
		summarize;
	end
endmodule // tb
